// ===== hw/pcc_cap_regs.sv
// Purpose: Capability register bank with vendor overvoltage fault reporting
// Assumes: Byte register port from the serial interface, same clock
// Notes: Overvoltage comparator input arrives from an asynchronous monitor
`timescale 1ns/10ps
`default_nettype none
module pcc_cap_regs (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register port
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ack,
  // Voltage monitor
  input wire logic [7:0] i_vbus_level,
  input wire logic i_is_source,
  // Fault pin and status
  output logic o_fault_pin,
  output logic o_drain_stop_valid
);
  import pcc_pkg::*;

  logic rom_hit;
  logic [7:0] rom_data;
  logic [7:0] ov_thresh_ff;
  logic [7:0] vnd_fault_ff;
  logic [7:0] rdata_ff;
  logic ack_ff;
  logic fault_pin_ff;
  logic drain_ok_ff;
  logic [7:0] lvl_s1_ff;
  logic [7:0] lvl_s2_ff;
  logic [7:0] lvl_s3_ff;
  logic [7:0] lvl_ok_ff;
  logic src_s1_ff;
  logic src_s2_ff;
  logic src_s3_ff;
  logic src_ok_ff;
  logic [7:0] nxt_rdata;
  logic ov_now;
  logic fault_clr;
  logic sel_cap;
  logic sel_ov_thresh;
  logic sel_fault;
  logic [7:0] cap_one_img;
  logic [7:0] cap_two_lo_img;
  logic [7:0] cap_two_hi_img;
  logic [7:0] std_in_img;
  logic [7:0] field_img;
  logic img_ok;

  pcc_cap_rom u_rom (
    .i_addr(i_reg_addr),
    .o_hit(rom_hit),
    .o_data(rom_data)
  );

  // Three-stage capture of the asynchronous monitor level; bits are caught one by one,
  // so a word taken mid-change is held back by the agree test below
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lvl_s1_ff <= 8'h00;
      lvl_s2_ff <= 8'h00;
      lvl_s3_ff <= 8'h00;
    end else begin
      lvl_s1_ff <= i_vbus_level;
      lvl_s2_ff <= lvl_s1_ff;
      lvl_s3_ff <= lvl_s2_ff;
    end
  end

  // Three-stage capture of the asynchronous source-role level
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      src_s1_ff <= 1'b0;
      src_s2_ff <= 1'b0;
      src_s3_ff <= 1'b0;
    end else begin
      src_s1_ff <= i_is_source;
      src_s2_ff <= src_s1_ff;
      src_s3_ff <= src_s2_ff;
    end
  end

  // Accept a new level only once the second and third stages agree
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lvl_ok_ff <= 8'h00;
    end else if (lvl_s2_ff == lvl_s3_ff) begin
      lvl_ok_ff <= lvl_s3_ff;
    end
  end

  // Accept a new source role only once the second and third stages agree
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      src_ok_ff <= 1'b0;
    end else if (src_s2_ff == src_s3_ff) begin
      src_ok_ff <= src_s3_ff;
    end
  end

  // Address decode shared by the write paths and the read mux
  always_comb begin
    sel_cap = 1'b0;
    sel_ov_thresh = 1'b0;
    sel_fault = 1'b0;
    case (i_reg_addr)
      ADDR_CAP_ONE_HI: begin
        sel_cap = 1'b1;
      end
      ADDR_CAP_TWO_LO: begin
        sel_cap = 1'b1;
      end
      ADDR_CAP_TWO_HI: begin
        sel_cap = 1'b1;
      end
      ADDR_STD_IN_CAP: begin
        sel_cap = 1'b1;
      end
      ADDR_OV_THRESH: begin
        sel_ov_thresh = 1'b1;
      end
      ADDR_VND_FAULT: begin
        sel_fault = 1'b1;
      end
      default: begin
        sel_cap = 1'b0;
        sel_ov_thresh = 1'b0;
        sel_fault = 1'b0;
      end
    endcase
  end

  // Overvoltage threshold, writable; capability bytes have no write path at all
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ov_thresh_ff <= OV_THRESH_RST;
    end else if (i_reg_wr && sel_ov_thresh) begin
      ov_thresh_ff <= i_reg_wdata;
    end
  end

  // Strict compare: a level equal to the threshold is not an overvoltage
  always_comb begin
    ov_now = 1'b0;
    if (lvl_ok_ff > ov_thresh_ff) begin
      ov_now = 1'b1;
    end
  end

  // Write one to the fault bit clears it; the other bits of the byte are ignored
  always_comb begin
    fault_clr = 1'b0;
    if (i_reg_wr && sel_fault && i_reg_wdata[VND_FAULT_OV_BIT]) begin
      fault_clr = 1'b1;
    end
  end

  // Sticky overvoltage fault; write one to clear, a new event wins
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      vnd_fault_ff <= 8'h00;
    end else if (ov_now) begin
      vnd_fault_ff[VND_FAULT_OV_BIT] <= 1'b1;
    end else if (fault_clr) begin
      vnd_fault_ff[VND_FAULT_OV_BIT] <= 1'b0;
    end
  end

  // Fault pin follows the latched fault; it also rises with a live comparison,
  // so the pin and the status bit change on the same edge
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fault_pin_ff <= 1'b0;
    end else begin
      fault_pin_ff <= ov_now | (vnd_fault_ff[VND_FAULT_OV_BIT] & ~fault_clr);
    end
  end

  // Stop threshold pair usable only while sourcing; the role passes the same
  // filter as the level, so validity trails the role input by about five cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      drain_ok_ff <= 1'b0;
    end else begin
      drain_ok_ff <= src_ok_ff & CAP_ONE_HI_VAL[CAP1_FORCE_DIS_BIT];
    end
  end

  // Capability byte one: discharge, measurement and pull-up fields
  always_comb begin
    cap_one_img = 8'h00;
    cap_one_img[CAP1_OC_REPORT_BIT] = 1'b0;
    cap_one_img[CAP1_OV_REPORT_BIT] = 1'b0;
    cap_one_img[CAP1_BLEED_BIT] = 1'b1;
    cap_one_img[CAP1_FORCE_DIS_BIT] = 1'b1;
    cap_one_img[CAP1_MEAS_ALARM_BIT] = 1'b1;
    cap_one_img[CAP1_PULLUP_LSB +: 2] = PULLUP_3A_1A5_DEFAULT;
  end

  // Capability byte two, low half: thresholds, alarm step and cable power
  always_comb begin
    cap_two_lo_img = 8'h00;
    cap_two_lo_img[CAP2_SINK_DETACH_BIT] = 1'b1;
    cap_two_lo_img[CAP2_DRAIN_STOP_BIT] = 1'b1;
    cap_two_lo_img[CAP2_ALARM_STEP_LSB +: 2] = ALARM_STEP_25MV;
    cap_two_lo_img[CAP2_CABLE_PWR_LSB +: 3] = CABLE_PWR_100MW;
    cap_two_lo_img[CAP2_CABLE_OC_BIT] = 1'b1;
  end

  // Capability byte two, high half: watchdog only, the rest reserved
  always_comb begin
    cap_two_hi_img = 8'h00;
    cap_two_hi_img[CAP3_WATCHDOG_BIT] = 1'b1;
  end

  // Standard inputs: none of the external fault or force-off inputs exist
  always_comb begin
    std_in_img = 8'h00;
    std_in_img[STDIN_EXT_OV_BIT] = 1'b0;
    std_in_img[STDIN_EXT_OC_BIT] = 1'b0;
    std_in_img[STDIN_FORCE_OFF_BIT] = 1'b0;
  end

  // Field view of the addressed capability byte
  always_comb begin
    field_img = 8'h00;
    case (i_reg_addr)
      ADDR_CAP_ONE_HI: begin
        field_img = cap_one_img;
      end
      ADDR_CAP_TWO_LO: begin
        field_img = cap_two_lo_img;
      end
      ADDR_CAP_TWO_HI: begin
        field_img = cap_two_hi_img;
      end
      ADDR_STD_IN_CAP: begin
        field_img = std_in_img;
      end
      default: begin
        field_img = 8'h00;
      end
    endcase
  end

  // The stored image is trusted only while it agrees bit for bit with the field
  // view; a damaged cell then reads as its field value instead
  assign img_ok = rom_data == field_img;

  // Read mux; writes to capability bytes are dropped since they have no storage
  always_comb begin
    nxt_rdata = 8'h00;
    if (sel_cap && rom_hit) begin
      nxt_rdata = img_ok ? rom_data : field_img;
    end else if (sel_ov_thresh) begin
      nxt_rdata = ov_thresh_ff;
    end else if (sel_fault) begin
      nxt_rdata = vnd_fault_ff;
    end
  end

  // Every strobe is answered, unmapped and read-only addresses too
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= i_reg_rd | i_reg_wr;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_ff <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_ack = ack_ff;
  assign o_fault_pin = fault_pin_ff;
  assign o_drain_stop_valid = drain_ok_ff;
endmodule
`default_nettype wire

// ===== hw/pcc_pkg.sv
// Purpose: Constants for the port controller capability register bank
// Assumes: Byte-wide register access at 8-bit addresses
// Notes: Capability bytes are fixed values held as nonvolatile defaults
package pcc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_CAP_ONE_HI = 8'h25;
  localparam logic [7:0] ADDR_CAP_TWO_LO = 8'h26;
  localparam logic [7:0] ADDR_CAP_TWO_HI = 8'h27;
  localparam logic [7:0] ADDR_STD_IN_CAP = 8'h28;
  localparam logic [7:0] ADDR_OV_THRESH = 8'hCC;
  localparam logic [7:0] ADDR_VND_FAULT = 8'hCD;
  // Field positions, capability one high byte
  localparam int CAP1_OC_REPORT_BIT = 6;
  localparam int CAP1_OV_REPORT_BIT = 5;
  localparam int CAP1_BLEED_BIT = 4;
  localparam int CAP1_FORCE_DIS_BIT = 3;
  localparam int CAP1_MEAS_ALARM_BIT = 2;
  localparam int CAP1_PULLUP_LSB = 0;
  // Field positions, capability two low byte
  localparam int CAP2_SINK_DETACH_BIT = 7;
  localparam int CAP2_DRAIN_STOP_BIT = 6;
  localparam int CAP2_ALARM_STEP_LSB = 4;
  localparam int CAP2_CABLE_PWR_LSB = 1;
  localparam int CAP2_CABLE_OC_BIT = 0;
  // Field positions, capability two high byte and standard input byte
  localparam int CAP3_WATCHDOG_BIT = 0;
  localparam int STDIN_EXT_OV_BIT = 2;
  localparam int STDIN_EXT_OC_BIT = 1;
  localparam int STDIN_FORCE_OFF_BIT = 0;
  // Vendor fault register field
  localparam int VND_FAULT_OV_BIT = 1;
  // Field values
  localparam logic [1:0] PULLUP_DEFAULT_ONLY = 2'h0;
  localparam logic [1:0] PULLUP_1A5_DEFAULT = 2'h1;
  localparam logic [1:0] PULLUP_3A_1A5_DEFAULT = 2'h2;
  localparam logic [1:0] ALARM_STEP_25MV = 2'h0;
  localparam logic [1:0] ALARM_STEP_50MV = 2'h1;
  localparam logic [1:0] ALARM_STEP_100MV = 2'h2;
  localparam logic [2:0] CABLE_PWR_100MW = 3'h0;
  // Reset value of the overvoltage threshold (plain default)
  localparam logic [7:0] OV_THRESH_RST = 8'hFF;
  // Capability byte images
  localparam logic [7:0] CAP_ONE_HI_VAL = 8'h1E;
  localparam logic [7:0] CAP_TWO_LO_VAL = 8'hC1;
  localparam logic [7:0] CAP_TWO_HI_VAL = 8'h01;
  localparam logic [7:0] STD_IN_CAP_VAL = 8'h00;
endpackage

// ===== hw/pcc_cap_rom.sv
// Purpose: Fixed capability byte store, read by address
// Assumes: Values never change after manufacture
// Notes: Combinational lookup, registered by the caller
`timescale 1ns/10ps
`default_nettype none
module pcc_cap_rom (
  // Lookup
  input wire logic [7:0] i_addr,
  output logic o_hit,
  output logic [7:0] o_data
);
  import pcc_pkg::*;

  always_comb begin
    o_hit = 1'b1;
    case (i_addr)
      ADDR_CAP_ONE_HI: o_data = CAP_ONE_HI_VAL;
      ADDR_CAP_TWO_LO: o_data = CAP_TWO_LO_VAL;
      ADDR_CAP_TWO_HI: o_data = CAP_TWO_HI_VAL;
      ADDR_STD_IN_CAP: o_data = STD_IN_CAP_VAL;
      default: begin
        o_hit = 1'b0;
        o_data = 8'h00;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== test/pcc_cap_regs_checker.sv
// Purpose: Port timing and capability image checks
// Assumes: Strobes last one cycle
// Notes: Bound to every pcc_cap_regs
`timescale 1ns/10ps
`default_nettype none
module pcc_cap_regs_checker (
  // Watched ports
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic i_is_source,
  input wire logic o_fault_pin,
  input wire logic o_drain_stop_valid
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ack_follows_a: assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack) else $error("no ack");
  ack_single_a: assert property (!(i_reg_rd || i_reg_wr) |=> !o_reg_ack) else $error("extra ack");
  cap_one_a: assert property (i_reg_rd && i_reg_addr == 8'h25 |=> o_reg_rdata == 8'h1E)
    else $error("bad byte at 25");
  cap_two_lo_a: assert property (i_reg_rd && i_reg_addr == 8'h26 |=> o_reg_rdata == 8'hC1)
    else $error("bad byte at 26");
  cap_two_hi_a: assert property (i_reg_rd && i_reg_addr == 8'h27 |=> o_reg_rdata == 8'h01)
    else $error("bad byte at 27");
  std_in_a: assert property (i_reg_rd && i_reg_addr == 8'h28 |=> o_reg_rdata == 8'h00)
    else $error("bad byte at 28");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata moved");
  drain_valid_a: assert property ($rose(i_is_source) |-> ##[1:8] o_drain_stop_valid)
    else $error("drain stop not valid");
  fault_sticky_a: assert property (o_fault_pin && !i_reg_wr |=> o_fault_pin)
    else $error("fault pin dropped");
  cover property (i_reg_wr && i_reg_addr == 8'h25);
  cover property ($rose(o_fault_pin));
  cover property ($fell(o_fault_pin));
endmodule
bind pcc_cap_regs pcc_cap_regs_checker chk_u (.i_clk_sys, .i_rst, .i_reg_rd, .i_reg_wr,
  .i_reg_addr, .o_reg_rdata, .o_reg_ack, .i_is_source, .o_fault_pin, .o_drain_stop_valid);
`default_nettype wire

// ===== test/pcc_host_model.sv
// Purpose: Port manager issuing byte register transfers
// Assumes: One strobe cycle per request
// Notes: Idle address and data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module pcc_host_model (
  // Bus
  input wire logic i_clk_sys,
  input wire logic i_ack,
  input wire logic [7:0] i_rdata,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q, output logic ok);
    ok = 1'b0;
    @(negedge i_clk_sys);
    {o_rd, o_wr, o_addr, o_wdata} = {~w, w, a, d};
    @(negedge i_clk_sys);
    {o_rd, o_wr, o_addr, o_wdata} = {2'b00, ~a, ~d};
    for (int n = 0; n < 4 && !ok; n++) begin
      if (i_ack === 1'b1) begin
        ok = 1'b1;
        q = i_rdata;
      end else begin
        @(negedge i_clk_sys);
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== test/port_controller_capability_registers_bench.sv
// Purpose: Self-checking bench for the capability bank
// Assumes: Inputs change on the falling edge
// Notes: Voltage codes are raw monitor levels
`timescale 1ns/10ps
`default_nettype none
module port_controller_capability_registers_bench;
  logic i_clk_sys, i_rst, i_is_source, rd, wr, ack, fault, dsv;
  logic [7:0] i_vbus_level, addr, wdata, rdata, q;
  int failures = 0;
  int samples_checked = 0;
  pcc_host_model host_u (.i_clk_sys(i_clk_sys), .i_ack(ack), .i_rdata(rdata), .o_rd(rd),
    .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  pcc_cap_regs dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_vbus_level(i_vbus_level), .i_is_source(i_is_source), .o_fault_pin(fault),
    .o_drain_stop_valid(dsv));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task complete_run;
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task xf(input logic w, input logic [7:0] a, d);
    logic ok;
    host_u.xfer(w, a, d, q, ok);
    if (!ok) begin
      failures++;
      complete_run();
    end
  endtask
  task wait_lvl(input logic use_dsv, input logic v);
    for (int n = 0; n < 20 && (use_dsv ? dsv : fault) !== v; n++) @(negedge i_clk_sys);
    chk({7'h00, use_dsv ? dsv : fault}, {7'h00, v});
    if ((use_dsv ? dsv : fault) !== v) complete_run();
  endtask
  task scen_caps;
    xf(1'b0, 8'h25, 8'h00); chk(q, 8'h1E);
    xf(1'b0, 8'h26, 8'h00); chk(q, 8'hC1);
    xf(1'b0, 8'h27, 8'h00); chk(q, 8'h01);
    xf(1'b0, 8'h28, 8'h00); chk(q, 8'h00);
    xf(1'b0, 8'h30, 8'h00); chk(q, 8'h00);
  endtask
  task scen_write_ignored;
    for (int a = 8'h25; a <= 8'h28; a++) xf(1'b1, a[7:0], 8'hFF);
    xf(1'b0, 8'h25, 8'h00); chk(q, 8'h1E);
    xf(1'b0, 8'h28, 8'h00); chk(q, 8'h00);
  endtask
  task scen_overvoltage;
    xf(1'b0, 8'hCC, 8'h00); chk(q, 8'hFF);
    xf(1'b1, 8'hCC, 8'h80);
    i_vbus_level = 8'h80;
    repeat (10) @(negedge i_clk_sys);
    chk({7'h00, fault}, 8'h00);
    i_vbus_level = 8'h81;
    wait_lvl(1'b0, 1'b1);
    xf(1'b0, 8'hCD, 8'h00); chk(q & 8'h02, 8'h02);
    i_vbus_level = 8'h10;
    repeat (10) @(negedge i_clk_sys);
    chk({7'h00, fault}, 8'h01);
    xf(1'b1, 8'hCD, 8'h02);
    wait_lvl(1'b0, 1'b0);
  endtask
  task scen_source;
    chk({7'h00, dsv}, 8'h00);
    i_is_source = 1'b1;
    wait_lvl(1'b1, 1'b1);
    i_is_source = 1'b0;
    wait_lvl(1'b1, 1'b0);
  endtask
  task scen_reset;
    xf(1'b1, 8'hCC, 8'h10);
    xf(1'b0, 8'hCC, 8'h00); chk(q, 8'h10);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    xf(1'b0, 8'hCC, 8'h00); chk(q, 8'hFF);
  endtask
  initial begin
    i_rst = 1'b1;
    i_is_source = 1'b0;
    i_vbus_level = 8'h00;
    repeat (16) @(negedge i_clk_sys);
    i_rst = 1'b0;
    scen_caps();
    scen_write_ignored();
    scen_overvoltage();
    scen_source();
    scen_reset();
    complete_run();
  end
endmodule
`default_nettype wire
